// ===== opdec_pkg.sv
package opdec_pkg;

  // ------------------------------------------------------------------
  // Instruction field positions
  // ------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int FILE_LSB = 0;           // 8-bit file address
  localparam int ACCESS_BIT = 8;         // RAM access select
  localparam int DEST_BIT = 9;           // Destination select
  localparam int BITPOS_LSB = 9;         // 3-bit bit position
  localparam int FAST_BIT = 0;           // Shadow select on return; call takes it from bit 8
  localparam int WIDE_LSB = 0;           // 12-bit move address
  localparam int TBLMODE_LSB = 0;        // 2-bit table pointer mode
  localparam logic [3:0] SECOND_MARK = 4'hF; // Top nibble of 2nd word

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int BANK_W = 4;
  localparam int DADDR_W = 12;
  localparam int PTR_W = 21;
  localparam int PC_W = 21;

  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
  localparam logic [1:0] PHASE_LAST = 2'h3; // Four clocks per cycle
  localparam logic [7:0] ACCESS_SPLIT = 8'h80; // Low half maps to bank 0
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

  // ------------------------------------------------------------------
  // Operation classes supplied by the opcode decoder
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_BYTE   = 4'h1,  // Byte-oriented, f/d/a
    OP_BIT    = 4'h2,  // Bit-oriented, f/b/a
    OP_MOVE   = 4'h3,  // Two-word register move
    OP_LIT8   = 4'h4,
    OP_LIT12  = 4'h5,  // Second word carries the low byte
    OP_GOTO   = 4'h6,  // 20-bit absolute target
    OP_CALL   = 4'h7,  // 20-bit target, fast bit
    OP_RET    = 4'h8,  // Fast bit
    OP_BRA11  = 4'h9,  // 11-bit relative
    OP_BRA8   = 4'hA,  // 8-bit relative
    OP_TABLE  = 4'hB,
    OP_MUL    = 4'hC,
    OP_SKIP   = 4'hD   // Conditional skip or PC write taken
  } op_class_type;

  typedef enum logic [1:0] {
    TBL_KEEP    = 2'h0,
    TBL_POSTINC = 2'h1,
    TBL_POSTDEC = 2'h2,
    TBL_PREINC  = 2'h3
  } tbl_mode_type;

  // Decoded operand bundle
  typedef struct packed {
    logic [DADDR_W-1:0] data_addr;
    logic [7:0] bit_mask;
    logic dest_file;
    logic [19:0] literal;
    logic [PC_W-1:0] target;
    logic fast;
  } operand_type;

  // Status flags
  typedef struct packed {
    logic negative;
    logic signed_wrap_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } status_type;

endpackage

// ===== alu_flags.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Status flag holder for the ALU
// --------------------------------------------------------------------
module alu_flags (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic flags_we,
  input wire opdec_pkg::status_type flags_in,
  output opdec_pkg::status_type flags
);

  opdec_pkg::status_type flags_reg;
  opdec_pkg::status_type flags_next;

  // Update only on instructions that touch status
  always_comb begin
    flags_next = flags_reg;
    if (flags_we) begin
      flags_next = flags_in;
    end
  end

  // Register the flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

// ===== operand_field_decoder.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module operand_field_decoder #(
  parameter int BANK_W = opdec_pkg::BANK_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic word_valid,
  input wire logic [15:0] instr_word,
  input wire opdec_pkg::op_class_type op_class,
  input wire logic [BANK_W-1:0] bank_pointer,
  input wire logic [opdec_pkg::PC_W-1:0] pc,
  input wire logic [7:0] alu_result,
  input wire logic [15:0] product_in,
  input wire logic [7:0] table_data_in,
  input wire logic table_write,
  input wire logic flags_we,
  input wire opdec_pkg::status_type flags_in,
  output opdec_pkg::operand_type operand,
  output logic operand_valid,
  output logic [7:0] working_accumulator,
  output logic file_write,
  output logic [opdec_pkg::PTR_W-1:0] program_read_pointer,
  output logic [opdec_pkg::PTR_W-1:0] table_access_addr,
  output logic [7:0] table_byte_latch,
  output logic [7:0] product_upper_byte,
  output logic [7:0] product_lower_byte,
  output logic shadow_save,
  output logic shadow_restore,
  output logic exec_phase,
  output logic flush_nop,
  output opdec_pkg::status_type status
);

  // ------------------------------------------------------------------
  // Cycle phase and sequencing state
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_FIRST  = 2'b00, // Expect a first word
    SEQ_SECOND = 2'b01, // Expect the second word of a pair
    SEQ_FLUSH  = 2'b10  // Extra no-op cycle after a PC change
  } seq_type;

  seq_type seq_reg, seq_next;
  logic [1:0] phase_reg, phase_next;          // Oscillator period count
  opdec_pkg::op_class_type held_reg, held_next; // Class of pending pair
  logic [15:0] first_reg, first_next;           // Held first word
  opdec_pkg::operand_type operand_reg, operand_next;
  logic operand_valid_reg, operand_valid_next;
  logic file_write_reg, file_write_next;
  logic [7:0] wacc_reg, wacc_next;
  logic [opdec_pkg::PTR_W-1:0] ptr_reg, ptr_next;
  logic [opdec_pkg::PTR_W-1:0] taddr_reg, taddr_next;
  logic [7:0] tlat_reg, tlat_next;
  logic [7:0] product_upper_byte_reg, product_upper_byte_next;
  logic [7:0] product_lower_byte_reg, product_lower_byte_next;
  logic ssave_reg, ssave_next;
  logic srest_reg, srest_next;
  logic flush_reg, flush_next;
  // Address formation shared by byte and bit forms
  function automatic logic [opdec_pkg::DADDR_W-1:0] bank_addr(
    input logic [15:0] w,
    input logic [BANK_W-1:0] bank
  );
    logic [7:0] f;
    f = w[opdec_pkg::FILE_LSB +: 8];
    if (!w[opdec_pkg::ACCESS_BIT]) begin
      // Access region ignores the bank pointer
      if (f < opdec_pkg::ACCESS_SPLIT) begin
        bank_addr = {4'h0, f};
      end else begin
        bank_addr = {opdec_pkg::ACCESS_HIGH_BANK, f};
      end
    end else begin
      bank_addr = {bank, f};
    end
  endfunction
  // Sign extension of short relative offsets to PC width
  function automatic logic [opdec_pkg::PC_W-1:0] sext11(
    input logic [10:0] n
  );
    sext11 = {{(opdec_pkg::PC_W - 11){n[10]}}, n};
  endfunction
  // Flag and output update
  alu_flags u_flags (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .flags_we(flags_we && exec_phase),
    .flags_in(flags_in),
    .flags(status)
  );

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic second_ok;
    logic [7:0] f;
    second_ok = (instr_word[15:12] == opdec_pkg::SECOND_MARK);
    f = instr_word[7:0];
    seq_next = seq_reg;
    phase_next = phase_reg + 2'h1;
    held_next = held_reg;
    first_next = first_reg;
    operand_next = operand_reg;
    operand_valid_next = 1'b0;
    file_write_next = 1'b0;
    wacc_next = wacc_reg;
    ptr_next = ptr_reg;
    taddr_next = taddr_reg;
    tlat_next = tlat_reg;
    product_upper_byte_next = product_upper_byte_reg;
    product_lower_byte_next = product_lower_byte_reg;
    ssave_next = 1'b0;
    srest_next = 1'b0;
    flush_next = 1'b0;
    // Work happens only in the last period of each instruction cycle
    // The flush cycle runs out even with no word present
    if (exec_phase && (word_valid || seq_reg == SEQ_FLUSH)) begin
      unique case (seq_reg)
        SEQ_FLUSH: begin
          seq_next = SEQ_FIRST;
        end
        SEQ_SECOND: begin
          seq_next = SEQ_FIRST;
          operand_valid_next = 1'b1;
          if (held_reg == opdec_pkg::OP_MOVE) begin
            operand_next.data_addr = instr_word[11:0];
            file_write_next = 1'b1;
          end else if (held_reg == opdec_pkg::OP_LIT12) begin
            operand_next.literal = {8'h00, first_reg[3:0], f};
          end else begin
            operand_next.literal = {instr_word[11:0], first_reg[7:0]};
            operand_next.target = {instr_word[11:0], first_reg[7:0], 1'b0};
            seq_next = SEQ_FLUSH;
            if (held_reg == opdec_pkg::OP_CALL) begin
              ssave_next = first_reg[8];
              operand_next.fast = first_reg[8];
            end
          end
        end
        SEQ_FIRST: begin
          operand_valid_next = 1'b1;
          unique case (second_ok ? opdec_pkg::OP_NONE : op_class)
            opdec_pkg::OP_BYTE: begin
              operand_next.data_addr = bank_addr(instr_word, bank_pointer);
              operand_next.dest_file = instr_word[opdec_pkg::DEST_BIT];
              file_write_next = instr_word[opdec_pkg::DEST_BIT];
              if (!instr_word[opdec_pkg::DEST_BIT]) begin
                wacc_next = alu_result;
              end
            end
            opdec_pkg::OP_BIT: begin
              operand_next.data_addr = bank_addr(instr_word, bank_pointer);
              operand_next.bit_mask =
                8'h01 << instr_word[opdec_pkg::BITPOS_LSB +: 3];
              file_write_next = 1'b1;
            end
            opdec_pkg::OP_MOVE, opdec_pkg::OP_GOTO, opdec_pkg::OP_CALL,
            opdec_pkg::OP_LIT12: begin
              operand_valid_next = 1'b0;
              held_next = op_class;
              first_next = instr_word;
              seq_next = SEQ_SECOND;
              if (op_class == opdec_pkg::OP_MOVE) begin
                // Source reaches all of data space, bank unused
                operand_next.data_addr = instr_word[11:0];
              end
            end
            opdec_pkg::OP_LIT8: begin
              operand_next.literal = {12'h000, f};
              wacc_next = f;
            end
            opdec_pkg::OP_BRA11: begin
              operand_next.target = pc + (sext11(instr_word[10:0]) << 1);
              seq_next = SEQ_FLUSH;
            end
            opdec_pkg::OP_BRA8: begin
              operand_next.target =
                pc + (sext11({{3{f[7]}}, f}) << 1);
              seq_next = SEQ_FLUSH;
            end
            opdec_pkg::OP_RET: begin
              // Only the fast bit matters; other low bits are ignored
              operand_next.fast = instr_word[opdec_pkg::FAST_BIT];
              srest_next = instr_word[opdec_pkg::FAST_BIT];
              seq_next = SEQ_FLUSH;
            end
            opdec_pkg::OP_TABLE: begin
              unique case (opdec_pkg::tbl_mode_type'(instr_word[1:0]))
                opdec_pkg::TBL_KEEP: taddr_next = ptr_reg;
                opdec_pkg::TBL_POSTINC: begin
                  taddr_next = ptr_reg;
                  ptr_next = ptr_reg + 21'h000001;
                end
                opdec_pkg::TBL_POSTDEC: begin
                  taddr_next = ptr_reg;
                  ptr_next = ptr_reg - 21'h000001;
                end
                opdec_pkg::TBL_PREINC: begin
                  taddr_next = ptr_reg + 21'h000001;
                  ptr_next = ptr_reg + 21'h000001;
                end
              endcase
              if (!table_write) begin
                tlat_next = table_data_in;
              end
            end
            opdec_pkg::OP_MUL: begin
              product_upper_byte_next = product_in[15:8];
              product_lower_byte_next = product_in[7:0];
            end
            opdec_pkg::OP_SKIP: begin
              seq_next = SEQ_FLUSH;
            end
            default: begin
              // A lone second word falls here and acts as no-op
              operand_valid_next = 1'b0;
            end
          endcase
        end
        default: seq_next = SEQ_FIRST;
      endcase
      flush_next = (seq_next == SEQ_FLUSH);
    end
  end
  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_reg <= SEQ_FIRST;
      phase_reg <= 2'h0;
      held_reg <= opdec_pkg::OP_NONE;
      first_reg <= 16'h0000;
      operand_reg <= '0;
      operand_valid_reg <= 1'b0;
      file_write_reg <= 1'b0;
      wacc_reg <= opdec_pkg::BYTE_RST;
      ptr_reg <= opdec_pkg::PTR_RST;
      taddr_reg <= opdec_pkg::PTR_RST;
      tlat_reg <= opdec_pkg::BYTE_RST;
      product_upper_byte_reg <= opdec_pkg::BYTE_RST;
      product_lower_byte_reg <= opdec_pkg::BYTE_RST;
      ssave_reg <= 1'b0;
      srest_reg <= 1'b0;
      flush_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      phase_reg <= phase_next;
      held_reg <= held_next;
      first_reg <= first_next;
      operand_reg <= operand_next;
      operand_valid_reg <= operand_valid_next;
      file_write_reg <= file_write_next;
      wacc_reg <= wacc_next;
      ptr_reg <= ptr_next;
      taddr_reg <= taddr_next;
      tlat_reg <= tlat_next;
      product_upper_byte_reg <= product_upper_byte_next;
      product_lower_byte_reg <= product_lower_byte_next;
      ssave_reg <= ssave_next;
      srest_reg <= srest_next;
      flush_reg <= flush_next;
    end
  end
  // Outputs come straight from flip-flops, except exec_phase, decoded from phase_reg
  assign exec_phase = (phase_reg == opdec_pkg::PHASE_LAST);
  assign operand = operand_reg;
  assign operand_valid = operand_valid_reg;
  assign file_write = file_write_reg;
  assign working_accumulator = wacc_reg;
  assign program_read_pointer = ptr_reg;
  assign table_access_addr = taddr_reg;
  assign table_byte_latch = tlat_reg;
  assign product_upper_byte = product_upper_byte_reg;
  assign product_lower_byte = product_lower_byte_reg;
  assign shadow_save = ssave_reg;
  assign shadow_restore = srest_reg;
  assign flush_nop = flush_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  wire logic first_take = exec_phase && word_valid && // Real first word
    seq_reg == SEQ_FIRST && instr_word[15:12] != opdec_pkg::SECOND_MARK;
  phase_wrap_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) phase_reg == 2'h3 |=> phase_reg == 2'h0)
    else $error("phase did not wrap after four periods");
  bit_onehot_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) $onehot0(operand_reg.bit_mask))
    else $error("bit mask not one-hot");
  dest_write_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) first_take && op_class == opdec_pkg::OP_BYTE |=>
    file_write == $past(instr_word[9]))
    else $error("destination select wrong");
  access_bank_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) first_take && op_class == opdec_pkg::OP_BYTE &&
    instr_word[8] |=>
    operand.data_addr == {$past(bank_pointer), $past(instr_word[7:0])})
    else $error("banked address wrong");
  access_low_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) first_take && op_class == opdec_pkg::OP_BYTE &&
    !instr_word[8] && !instr_word[7] |=> operand.data_addr[11:8] == 4'h0)
    else $error("access region address wrong");
  ptr_postinc_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) first_take && op_class == opdec_pkg::OP_TABLE &&
    instr_word[1:0] == 2'h1 |=>
    program_read_pointer == $past(program_read_pointer) + 21'h000001)
    else $error("post-increment wrong");
  mul_bytes_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) first_take && op_class == opdec_pkg::OP_MUL |=>
    {product_upper_byte, product_lower_byte} == $past(product_in) &&
    $stable(working_accumulator))
    else $error("product bytes wrong");
  fast_ret_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) shadow_restore |-> !shadow_save && flush_nop)
    else $error("restore without flush");
  move_src_a: assert property (@(posedge sys_clk)
    disable iff (!arst_n) first_take && op_class == opdec_pkg::OP_MOVE |=>
    operand.data_addr == $past(instr_word[11:0]))
    else $error("move source address wrong");

endmodule

// ===== prog_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Program memory stand-in feeding instruction words
// ------------------------------------------------------------------
module prog_mem_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic exec_phase,
  input wire logic slow,
  output logic word_valid,
  output logic [15:0] instr_word,
  output opdec_pkg::op_class_type op_class
);
  // One queued word; tied marks the second word of a pair
  typedef struct packed {
    logic tied;
    opdec_pkg::op_class_type cls;
    logic [15:0] word;
  } entry_type;
  entry_type fifo[$]; // Words not yet presented
  entry_type head;
  logic [2:0] gap_reg = 3'h0; // Idle cycles before the next word

  initial begin
    word_valid = 1'b0;
    instr_word = 16'h0000;
    op_class = opdec_pkg::OP_NONE;
  end

  // Bench queues words here
  task automatic push(input logic tied, input opdec_pkg::op_class_type c,
                      input logic [15:0] word);
    fifo.push_back({tied, c, word});
  endtask

  // True once nothing is queued or presented
  function automatic logic idle();
    return fifo.size() == 0 && !word_valid;
  endfunction

  // A word stands until taken; a pair's second word follows at once
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_valid <= 1'b0;
      gap_reg <= 3'h0;
    end else if (word_valid && !exec_phase) begin
      // Held until the decoder's execute phase
    end else if (fifo.size() != 0 && (fifo[0].tied || gap_reg == 3'h0)) begin
      head = fifo.pop_front();
      word_valid <= 1'b1;
      instr_word <= head.word;
      op_class <= head.cls;
      gap_reg <= slow ? 3'h5 : 3'h0;
    end else begin
      // Released: never leave the old word looking valid
      word_valid <= 1'b0;
      instr_word <= ~instr_word;
      if (gap_reg != 3'h0) begin
        gap_reg <= gap_reg - 3'h1;
      end
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  typedef struct packed {
    opdec_pkg::op_class_type cls;
    opdec_pkg::operand_type op;
  } note_type;
  note_type notes[$]; // Expected operands, oldest first
  note_type nt;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic slow = 1'b0;
  logic table_write = 1'b0;
  logic flags_we = 1'b0;
  logic word_valid, exec_phase, operand_valid, file_write;
  logic shadow_save, shadow_restore, flush_nop;
  logic [15:0] instr_word, w;
  logic [15:0] product_in = 16'h0000;
  logic [3:0] bk;
  logic [3:0] bank_pointer = 4'h0;
  logic [20:0] pc = 21'h001000; // Held: branch targets derive from it
  logic [20:0] ptr, nxt, acc, program_read_pointer, table_access_addr;
  logic [7:0] alu_result = 8'h00;
  logic [7:0] table_data_in = 8'h00;
  logic [7:0] working_accumulator, table_byte_latch, a0, td;
  logic [7:0] product_upper_byte, product_lower_byte;
  opdec_pkg::op_class_type op_class;
  opdec_pkg::status_type flags_in = 5'h00;
  opdec_pkg::status_type status;
  opdec_pkg::operand_type operand, e;
  logic [1:0] modes [6] = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2};
  opdec_pkg::op_class_type brc [3] =
    '{opdec_pkg::OP_GOTO, opdec_pkg::OP_BRA11, opdec_pkg::OP_BRA8};
  logic [15:0] brw [3] = '{16'h00AB, 16'h07FF, 16'h0080};
  logic [20:0] brt [3] = '{21'h024756, 21'h000FFE, 21'h000F00};
  int seed = 76;
  int err_total = 0;
  int cmp_count = 0;
  int fw_cnt = 0, sv_cnt = 0, rs_cnt = 0, fl_cnt = 0, f0;

  always #5 sys_clk = ~sys_clk;

  operand_field_decoder #(.BANK_W(4)) dut (.sys_clk(sys_clk),
    .arst_n(arst_n), .word_valid(word_valid), .instr_word(instr_word),
    .op_class(op_class), .bank_pointer(bank_pointer), .pc(pc),
    .alu_result(alu_result), .product_in(product_in),
    .table_data_in(table_data_in), .table_write(table_write),
    .flags_we(flags_we), .flags_in(flags_in), .operand(operand),
    .operand_valid(operand_valid),
    .working_accumulator(working_accumulator), .file_write(file_write),
    .program_read_pointer(program_read_pointer),
    .table_access_addr(table_access_addr),
    .table_byte_latch(table_byte_latch),
    .product_upper_byte(product_upper_byte),
    .product_lower_byte(product_lower_byte), .shadow_save(shadow_save),
    .shadow_restore(shadow_restore), .exec_phase(exec_phase),
    .flush_nop(flush_nop), .status(status));

  prog_mem_model prog (.sys_clk(sys_clk), .arst_n(arst_n),
    .exec_phase(exec_phase), .slow(slow), .word_valid(word_valid),
    .instr_word(instr_word), .op_class(op_class));

  // ----------------------------------------------------------------
  // Compare, verdict and instruction issue
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Queue words at the falling edge so the partner never races us
  task automatic run(input opdec_pkg::op_class_type c, input logic [15:0] w1,
    input logic two, input logic [15:0] w2,
    input opdec_pkg::operand_type x, input logic noted);
    @(negedge sys_clk);
    if (noted) notes.push_back({c, x});
    prog.push(1'b0, c, w1);
    if (two) prog.push(1'b1, opdec_pkg::OP_NONE, w2);
    for (int i = 0; i < 64 && !prog.idle(); i++) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    if (noted) check(notes.size(), 0);
    notes.delete();
  endtask

  // Field checks per class; other fields are left open by the format
  task automatic judge(input note_type n);
    case (n.cls)
      opdec_pkg::OP_BYTE, opdec_pkg::OP_BIT: begin
        check(operand.data_addr, n.op.data_addr);
        if (n.cls == opdec_pkg::OP_BYTE) begin
          check(operand.dest_file, n.op.dest_file);
        end else begin
          check(operand.bit_mask, n.op.bit_mask);
        end
      end
      // The pair completes with the target address on show
      opdec_pkg::OP_MOVE:
        check(operand.data_addr, n.op.literal[11:0]);
      opdec_pkg::OP_LIT8, opdec_pkg::OP_LIT12:
        check(operand.literal, n.op.literal);
      opdec_pkg::OP_GOTO, opdec_pkg::OP_BRA11, opdec_pkg::OP_BRA8,
      opdec_pkg::OP_CALL: check(operand.target, n.op.target);
      default: ;
    endcase
    if (n.cls inside {opdec_pkg::OP_CALL, opdec_pkg::OP_RET}) begin
      check(operand.fast, n.op.fast);
    end
  endtask

  // Watch outputs: count pulses, match results with the oldest note
  always @(posedge sys_clk) begin
    if (arst_n === 1'b1) begin
      if (file_write === 1'b1) fw_cnt++;
      if (shadow_save === 1'b1) sv_cnt++;
      if (shadow_restore === 1'b1) rs_cnt++;
      if (flush_nop === 1'b1) fl_cnt++;
      if (operand_valid === 1'b1 && notes.size() != 0) begin
        nt = notes.pop_front();
        judge(nt);
      end
    end
  end

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Random byte and bit ops; opcode bits left random on purpose
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      bk = 4'($random(seed));
      w = 16'($random(seed));
      w[15] = 1'b0; // Top nibble never reads as a second word
      bank_pointer <= bk;
      alu_result <= w[15:8] ^ 8'h5A;
      slow <= i[2];
      e = '0;
      e.data_addr = {(w[8] ? bk : (w[7:0] < opdec_pkg::ACCESS_SPLIT) ?
        4'h0 : opdec_pkg::ACCESS_HIGH_BANK), w[7:0]};
      e.dest_file = w[9];
      e.bit_mask = 8'h01 << w[11:9];
      f0 = fw_cnt;
      run(i[0] ? opdec_pkg::OP_BIT : opdec_pkg::OP_BYTE, w, 1'b0, w, e, 1);
      if (!i[0]) begin
        check(fw_cnt - f0, w[9]);
        if (!w[9]) check(working_accumulator, w[15:8] ^ 8'h5A);
      end
    end
    $display("test byte_bit done");
    slow <= 1'b0;
    bank_pointer <= 4'h3;
    e = '0;
    e.data_addr = 12'hABC;
    e.literal = 20'h00456;
    run(opdec_pkg::OP_MOVE, 16'hCABC, 1'b1, 16'hF456, e, 1'b1);
    e.literal = 20'h0005A;
    run(opdec_pkg::OP_LIT8, 16'h0E5A, 1'b0, 16'h0000, e, 1'b1);
    e.literal = 20'h007C3;
    run(opdec_pkg::OP_LIT12, 16'h0F07, 1'b1, 16'hF0C3, e, 1'b1);
    $display("test move_literal done");
    // Program counter changes each cost one flushed cycle
    for (int k = 0; k < 3; k++) begin
      f0 = fl_cnt;
      e.target = brt[k];
      run(brc[k], brw[k], k == 0, 16'hF123, e, 1'b1);
      check(fl_cnt - f0, 1);
    end
    for (int s = 0; s < 2; s++) begin
      f0 = sv_cnt;
      e.target = {20'hABC34, 1'b0};
      e.fast = s[0];
      run(opdec_pkg::OP_CALL, {7'h00, s[0], 8'h34}, 1, 16'hFABC, e, 1);
      check(sv_cnt - f0, s);
      f0 = rs_cnt;
      run(opdec_pkg::OP_RET, {4'h0, w[10:0], s[0]}, 1'b0, w, e, 1'b1);
      check(rs_cnt - f0, s);
    end
    f0 = fl_cnt;
    run(opdec_pkg::OP_SKIP, 16'h6400, 1'b0, w, e, 1'b0);
    check(fl_cnt - f0, 1);
    $display("test control done");
    // Pointer walk ends by wrapping below zero
    ptr = '0;
    foreach (modes[k]) begin
      td = 8'($random(seed));
      table_data_in <= td;
      nxt = modes[k] == 2'h2 ? ptr - 1 : modes[k] == 2'h0 ? ptr : ptr + 1;
      acc = modes[k] == 2'h3 ? nxt : ptr;
      run(opdec_pkg::OP_TABLE, {14'h0000, modes[k]}, 1'b0, w, e, 1'b0);
      check(table_access_addr, acc);
      check(program_read_pointer, nxt);
      check(table_byte_latch, td);
      ptr = nxt;
    end
    a0 = working_accumulator;
    product_in <= 16'($random(seed));
    run(opdec_pkg::OP_MUL, 16'h0200, 1'b0, w, e, 1'b0);
    check(product_upper_byte, product_in[15:8]);
    check(product_lower_byte, product_in[7:0]);
    check(working_accumulator, a0);
    flags_we <= 1'b1;
    flags_in <= 5'h15;
    run(opdec_pkg::OP_NONE, 16'h0000, 1'b0, w, e, 1'b0);
    check(status, 5'h15);
    flags_we <= 1'b0;
    flags_in <= 5'h0A;
    run(opdec_pkg::OP_NONE, 16'h0000, 1'b0, w, e, 1'b0);
    check(status, 5'h15);
    // A second word on its own must do nothing, whatever its class
    f0 = fw_cnt;
    run(opdec_pkg::OP_BYTE, 16'hF5A5, 1'b0, w, e, 1'b0);
    check(fw_cnt - f0, 0);
    check(working_accumulator, a0);
    $display("test table_mul_flags done");
    conclude();
  end
endmodule
